/* File: design/pzs_pkg.sv */
package pzs_pkg;
    // Bus and array shape
    localparam int PZS_DATA_W   = 36;
    localparam int PZS_LANES    = 4;
    localparam int PZS_LANE_W   = 9;
    localparam int PZS_ADDR_W   = 19;
    // Burst shape: four words, two low address bits step
    localparam int PZS_BURST_W  = 2;
    localparam int PZS_BURST_N  = 4;
    // Cycles from address cycle to data cycle (documentation only)
    localparam int PZS_LATENCY  = 2;
    // Values after reset
    localparam logic [PZS_BURST_W-1:0] PZS_CNT_RST  = 2'h0;
    localparam logic [PZS_DATA_W-1:0]  PZS_DATA_RST = 36'h0;
    localparam logic [PZS_LANES-1:0]   PZS_BW_OFF   = 4'hf;

    // Controller sequencing, one-hot
    typedef enum logic [1:0] {
        PZS_ST_IDLE  = 2'h1,
        PZS_ST_BURST = 2'h2
    } pzs_ctl_state_t;

    // Low address bits of a burst word; order high selects interleaved
    function automatic logic [PZS_BURST_W-1:0] pzs_burst_step(
        input logic [PZS_BURST_W-1:0] start,
        input logic [PZS_BURST_W-1:0] cnt,
        input logic                   order);
        pzs_burst_step = order ? (start ^ cnt) : (start + cnt);
    endfunction

    // Byte-lane merge; active-low selects pick the new lanes
    function automatic logic [PZS_DATA_W-1:0] pzs_merge(
        input logic [PZS_DATA_W-1:0] old_w,
        input logic [PZS_DATA_W-1:0] new_w,
        input logic [PZS_LANES-1:0]  sel_n);
        pzs_merge = old_w;
        for (int i = 0; i < PZS_LANES; i++) begin
            if (!sel_n[i]) begin
                pzs_merge[i*PZS_LANE_W +: PZS_LANE_W] =
                    new_w[i*PZS_LANE_W +: PZS_LANE_W];
            end
        end
    endfunction
endpackage

/* File: design/pzs_link_if.sv */
`timescale 1ns/1ps
interface pzs_link_if import pzs_pkg::*; ();
    // Address and control, driven by the controller
    logic [PZS_ADDR_W-1:0] addr;
    logic                  read_write;        // High reads
    logic                  advance_or_load;   // High advances
    logic                  chip_select_a_n;
    logic                  chip_select_b;
    logic                  chip_select_c_n;
    logic                  clock_gate_n;      // High suspends
    logic [PZS_LANES-1:0]  byte_write_selects; // Active low
    logic                  burst_order_select; // High interleaved
    logic                  out_enable_n;      // Asynchronous
    // Data bus halves and their enables (low drives)
    logic [PZS_DATA_W-1:0] ctl_dq;
    logic                  ctl_dq_oe_n;
    logic [PZS_DATA_W-1:0] dev_dq;
    logic                  dev_dq_oe_n;
    // Resolved bus level; undriven bus reads as zero
    logic [PZS_DATA_W-1:0] dq_bus;

    assign dq_bus = !dev_dq_oe_n ? dev_dq :
                    (!ctl_dq_oe_n ? ctl_dq : PZS_DATA_RST);

    modport dev (
        input  addr, read_write, advance_or_load, chip_select_a_n,
        input  chip_select_b, chip_select_c_n, clock_gate_n,
        input  byte_write_selects, burst_order_select, out_enable_n,
        input  dq_bus,
        output dev_dq, dev_dq_oe_n
    );
    modport ctl (
        output addr, read_write, advance_or_load, chip_select_a_n,
        output chip_select_b, chip_select_c_n, clock_gate_n,
        output byte_write_selects, burst_order_select, out_enable_n,
        output ctl_dq, ctl_dq_oe_n,
        input  dq_bus
    );
endinterface

/* File: design/pzs_sram_dev.sv */
// Overview of operation
// [RQ1] Load takes address and direction when enabled
// [RQ2] Load read drives data two cycles later
// [RQ3] Advance ignores address, selects; steps counter
// [RQ4] Burst read gives one word per cycle
// [RQ5] New load accepted on fourth burst word
// [RQ6] Burst write advances counter every enabled edge
// [RQ7] Controller drives write data two cycles later
// [RQ8] Deselect releases bus two cycles later
// [RQ9] Clock gate high freezes all state
// [RQ10] Burst direction fixed at load
// [RQ11] Selected only with all three selects active
// [RQ12] Burst order linear or interleaved, wraps
`timescale 1ns/1ps
module pzs_sram_dev import pzs_pkg::*; #(
    parameter int ADDR_W = PZS_ADDR_W
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    // Memory bus pins
    pzs_link_if.dev   link,
    // Status for the user side
    output logic      stat_burst_live_o,
    output logic      stat_suspended_o,
    output logic      stat_driving_o
);
    localparam int HI_W = ADDR_W - PZS_BURST_W;
    // One access per enabled edge:
    // edge one fills stage one, edge
    // two fills stage two and loads a
    // read word for its data cycle; a
    // write lands as that cycle ends.
    // Suspended edges move nothing.

    // Storage array, no reset
    logic [PZS_DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Decoded pin conditions
    logic                  run;       // Edge is not suspended
    logic                  sel;       // All selects active
    logic                  load;      // Load cycle
    // Burst state captured at load
    logic                  live_q;    // A burst may advance
    logic                  dir_wr_q;  // Burst direction
    logic [ADDR_W-1:0]     base_q;    // Loaded address
    logic [PZS_BURST_W-1:0] cnt_q;    // Word index in burst
    logic [PZS_BURST_W-1:0] cnt_d;    // Next word index
    // First pipeline stage (address cycle registered)
    logic                  s1_vld_q;
    logic                  s1_wr_q;
    logic [ADDR_W-1:0]     s1_addr_q;
    logic [PZS_LANES-1:0]  s1_bw_n_q;
    logic [ADDR_W-1:0]     s1_addr_d;
    // Second pipeline stage (data cycle follows)
    logic                  s2_vld_q;
    logic                  s2_wr_q;
    logic [ADDR_W-1:0]     s2_addr_q;
    logic [PZS_LANES-1:0]  s2_bw_n_q;
    // Read data path
    logic [PZS_DATA_W-1:0] dout_q;
    logic [PZS_DATA_W-1:0] rd_word;
    logic                  drv_q;     // Read word due on bus
    logic                  wr_now;    // Write lands this edge

    // Suspend gates every register below
    assign run = ~link.clock_gate_n; // [RQ9]

    // Chip select needs all three at their active levels
    assign sel = ~link.chip_select_a_n & link.chip_select_b
               & ~link.chip_select_c_n; // [RQ11]

    assign load = ~link.advance_or_load;
    assign cnt_d = cnt_q + 2'h1;

    // Address of the word this cycle stands for
    // Next index, so stage one holds
    // the word this edge stands for
    always_comb begin
        if (load) begin
            s1_addr_d = link.addr; // [RQ1]
        end else begin
            // External address ignored, counter steps
            s1_addr_d = {base_q[ADDR_W-1:PZS_BURST_W],
                         pzs_burst_step(base_q[PZS_BURST_W-1:0],
                                        cnt_d,
                                        link.burst_order_select)};
            // [RQ3] [RQ12]
        end
    end

    // Burst tracker: load, deselect or advance
    // Direction kept per burst; the
    // pin is ignored on advances
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            live_q   <= 1'b0;
            dir_wr_q <= 1'b0;
            base_q   <= '0;
            cnt_q    <= PZS_CNT_RST;
        end else if (run) begin
            if (load) begin
                if (sel) begin
                    // New access; may land on a burst's last word
                    live_q   <= 1'b1; // [RQ1] [RQ5]
                    base_q   <= link.addr;
                    dir_wr_q <= ~link.read_write; // [RQ10]
                    cnt_q    <= PZS_CNT_RST;
                end else begin
                    // Deselect or stop ends the burst
                    live_q <= 1'b0; // [RQ8]
                end
            end else if (live_q) begin
                // Counter wraps after four words
                cnt_q <= cnt_d; // [RQ3] [RQ6] [RQ12]
            end
        end
    end

    // Stage one: register the access of this cycle
    // Selects taken every cycle; a
    // write burst needs fresh ones
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s1_vld_q  <= 1'b0;
            s1_wr_q   <= 1'b0;
            s1_addr_q <= '0;
            s1_bw_n_q <= PZS_BW_OFF;
        end else if (run) begin
            // Advance after deselect is a no-op
            s1_vld_q  <= load ? sel : live_q; // [RQ3] [RQ8]
            // Direction on advances comes from the load
            s1_wr_q   <= load ? ~link.read_write : dir_wr_q; // [RQ10]
            s1_addr_q <= s1_addr_d;
            s1_bw_n_q <= link.byte_write_selects; // [RQ6]
        end
    end

    // Stage two: keep the access for its data cycle
    // Equal depth for reads and writes
    // avoids dead turnaround cycles
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s2_vld_q  <= 1'b0;
            s2_wr_q   <= 1'b0;
            s2_addr_q <= '0;
            s2_bw_n_q <= PZS_BW_OFF;
        end else if (run) begin
            s2_vld_q  <= s1_vld_q;
            s2_wr_q   <= s1_wr_q;
            s2_addr_q <= s1_addr_q;
            s2_bw_n_q <= s1_bw_n_q;
        end
    end

    // Write data is on the bus in the cycle after stage two loads
    // A suspended data cycle writes
    // nothing; the far end holds
    assign wr_now = run & s2_vld_q & s2_wr_q;

    // Read word, forwarding a write that lands on the same edge,
    // so write-then-read needs no dead cycle
    // Older writes are in the array
    always_comb begin
        rd_word = mem[s1_addr_q];
        if (wr_now && s2_addr_q == s1_addr_q) begin
            rd_word = pzs_merge(rd_word, link.dq_bus, s2_bw_n_q);
        end
    end

    // Array write in the data cycle
    always_ff @(posedge sys_clk_i) begin
        if (wr_now) begin
            // Data taken two cycles after the address cycle
            mem[s2_addr_q] <= pzs_merge(mem[s2_addr_q],
                                        link.dq_bus,
                                        s2_bw_n_q); // [RQ7]
        end
    end

    // Output register: one word per enabled cycle in a read burst
    // Held while suspended, so the bus
    // keeps the previous word
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            dout_q <= PZS_DATA_RST;
            drv_q  <= 1'b0;
        end else if (run) begin
            // Released when the access two cycles back was not a read
            drv_q <= s1_vld_q & ~s1_wr_q; // [RQ2] [RQ8]
            if (s1_vld_q && !s1_wr_q) begin
                dout_q <= rd_word; // [RQ2] [RQ4]
            end
        end
    end

    // Output enable pin overrides asynchronously
    // Gates only the bus, not the pipe
    assign link.dev_dq      = dout_q;
    assign link.dev_dq_oe_n = ~(drv_q & ~link.out_enable_n); // [RQ2]

    // Status
    // Suspend flag is the pin itself,
    // the gate of the current cycle
    assign stat_burst_live_o = live_q;
    assign stat_suspended_o  = link.clock_gate_n;
    assign stat_driving_o    = drv_q;
endmodule

/* File: design/pzs_sram_ctl.sv */
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module pzs_sram_ctl import pzs_pkg::*; (
    // Clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_i,
    // Request port
    input  wire logic                  req_valid_i,
    output logic                       req_ready_o,
    input  wire logic                  req_write_i,
    input  wire logic                  req_burst_i,
    input  wire logic [PZS_ADDR_W-1:0] req_addr_i,
    input  wire logic [PZS_LANES-1:0]  req_byte_en_i,
    // Suspend and burst order
    input  wire logic                  hold_i,
    input  wire logic                  order_i,
    // Write data pull
    output logic                       wdata_pull_o,
    input  wire logic [PZS_DATA_W-1:0] wdata_i,
    // Read data return
    output logic                       rdata_valid_o,
    output logic [PZS_DATA_W-1:0]      rdata_o,
    // Memory bus pins
    pzs_link_if.ctl                    link
);
    // Sequencer
    pzs_ctl_state_t        state_q;
    logic [PZS_BURST_W-1:0] left_q;   // Advances still to issue
    logic                  dir_wr_q;  // Burst direction
    logic [PZS_LANES-1:0]  bw_n_q;    // Burst byte selects
    logic                  take;      // Request accepted
    // Issued pin values
    logic                  hold_q;
    logic                  adv_q;
    logic                  sel_q;
    logic                  rw_q;
    logic [PZS_ADDR_W-1:0] addr_q;
    logic [PZS_LANES-1:0]  pin_bw_n_q;
    logic                  op_q;      // Pins carry an access
    logic                  order_q;   // Burst order of this access
    // Tracking pipeline, mirrors the device
    logic                  p1_vld_q;
    logic                  p1_wr_q;
    logic                  p2_vld_q;
    logic                  p2_wr_q;
    logic                  run;
    // Data pins
    logic [PZS_DATA_W-1:0] dq_q;
    logic                  dq_drv_q;
    logic                  rvld_q;
    logic [PZS_DATA_W-1:0] rdat_q;

    // New request only between bursts and outside suspend
    assign req_ready_o = (state_q == PZS_ST_IDLE) & ~hold_i;
    assign take        = req_valid_i & req_ready_o;
    assign run         = ~hold_q; // Device sees the same gate

    // Sequencer; a load may follow the last advance back to back
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q  <= PZS_ST_IDLE;
            left_q   <= PZS_CNT_RST;
            dir_wr_q <= 1'b0;
            bw_n_q   <= PZS_BW_OFF;
        end else begin
            case (state_q)
                PZS_ST_IDLE: begin
                    if (take && req_burst_i) begin
                        state_q  <= PZS_ST_BURST;
                        left_q   <= 2'(PZS_BURST_N - 1);
                        dir_wr_q <= req_write_i;
                        bw_n_q   <= ~req_byte_en_i;
                    end
                end
                PZS_ST_BURST: begin
                    if (!hold_i) begin
                        left_q <= left_q - 2'h1;
                        if (left_q == 2'h1) begin
                            state_q <= PZS_ST_IDLE; // [RQ5]
                        end
                    end
                end
                default: state_q <= PZS_ST_IDLE;
            endcase
        end
    end

    // Pin register; idle cycles become deselects
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            hold_q     <= 1'b0;
            adv_q      <= 1'b0;
            sel_q      <= 1'b0;
            rw_q       <= 1'b1;
            addr_q     <= '0;
            pin_bw_n_q <= PZS_BW_OFF;
            op_q       <= 1'b0;
            order_q    <= 1'b0;
        end else begin
            hold_q <= hold_i; // [RQ9]
            if (hold_i) begin
                op_q <= 1'b0; // Pins ignored while suspended
            end else if (state_q == PZS_ST_BURST) begin
                // Advance; address and selects left as they were
                adv_q      <= 1'b1; // [RQ3] [RQ6]
                pin_bw_n_q <= dir_wr_q ? bw_n_q : PZS_BW_OFF; // [RQ6]
                op_q       <= 1'b1;
            end else if (take) begin
                adv_q      <= 1'b0; // [RQ1]
                sel_q      <= 1'b1;
                rw_q       <= ~req_write_i;
                addr_q     <= req_addr_i;
                order_q    <= order_i; // [RQ12]
                pin_bw_n_q <= req_write_i ? ~req_byte_en_i : PZS_BW_OFF;
                op_q       <= 1'b1;
            end else begin
                adv_q      <= 1'b0; // [RQ8]
                sel_q      <= 1'b0;
                pin_bw_n_q <= PZS_BW_OFF;
                op_q       <= 1'b0;
            end
        end
    end

    // Track each access to its data cycle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            p1_vld_q <= 1'b0;
            p1_wr_q  <= 1'b0;
            p2_vld_q <= 1'b0;
            p2_wr_q  <= 1'b0;
        end else if (run) begin
            p1_vld_q <= op_q;
            p1_wr_q  <= adv_q ? p1_wr_q & p1_vld_q | p2hold() : ~rw_q;
            p2_vld_q <= p1_vld_q;
            p2_wr_q  <= p1_wr_q;
        end
    end

    // Direction on advances repeats the running burst's direction
    function automatic logic p2hold();
        p2hold = adv_q & ~p1_vld_q & dir_wr_q;
    endfunction

    // Write data pulled one cycle before its data cycle
    assign wdata_pull_o = run & p1_vld_q & p1_wr_q;

    // Data pins: drive write word in its data cycle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            dq_q     <= PZS_DATA_RST;
            dq_drv_q <= 1'b0;
        end else if (run) begin
            dq_drv_q <= p1_vld_q & p1_wr_q; // [RQ7]
            if (p1_vld_q && p1_wr_q) begin
                dq_q <= wdata_i; // [RQ7]
            end
        end
    end

    // Read return: capture bus in the read's data cycle
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rvld_q <= 1'b0;
            rdat_q <= PZS_DATA_RST;
        end else begin
            rvld_q <= run & p2_vld_q & ~p2_wr_q; // [RQ2] [RQ4]
            if (run && p2_vld_q && !p2_wr_q) begin
                rdat_q <= link.dq_bus;
            end
        end
    end

    // Pin outputs from flops, except output enable, which is tied low
    assign link.addr               = addr_q;
    assign link.read_write         = rw_q;
    assign link.advance_or_load    = adv_q;
    assign link.chip_select_a_n    = ~sel_q; // [RQ11]
    assign link.chip_select_b      = sel_q;
    assign link.chip_select_c_n    = ~sel_q;
    assign link.clock_gate_n       = hold_q;
    assign link.byte_write_selects = pin_bw_n_q;
    assign link.burst_order_select = order_q;
    assign link.out_enable_n       = 1'b0;
    assign link.ctl_dq             = dq_q;
    assign link.ctl_dq_oe_n        = ~dq_drv_q;
    assign rdata_valid_o           = rvld_q;
    assign rdata_o                 = rdat_q;
endmodule

/* File: testbench/pzs_link_checker.sv */
`timescale 1ns/1ps
module pzs_link_checker import pzs_pkg::*; (
    // Clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_i,
    // Link pins as seen on the wire
    input  wire logic                  read_write,
    input  wire logic                  advance_or_load,
    input  wire logic                  chip_select_a_n,
    input  wire logic                  chip_select_b,
    input  wire logic                  chip_select_c_n,
    input  wire logic                  clock_gate_n,
    input  wire logic                  ctl_dq_oe_n,
    input  wire logic [PZS_DATA_W-1:0] dev_dq,
    input  wire logic                  dev_dq_oe_n
);
    // Decoded commands on an enabled edge
    logic sel;
    logic ld_rd;
    logic ld_wr;
    logic desel;
    logic adv;
    assign sel   = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    assign ld_rd = !clock_gate_n && !advance_or_load && sel && read_write;
    assign ld_wr = !clock_gate_n && !advance_or_load && sel && !read_write;
    assign desel = !clock_gate_n && !advance_or_load && !sel;
    assign adv   = !clock_gate_n && advance_or_load;

    // One domain, so clock and reset are given once
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    a_read_two_later: assert property (
        ld_rd ##1 !clock_gate_n |=> !dev_dq_oe_n)
        else $error("load read word not driven");
    a_burst_last_word: assert property (
        ld_rd ##1 adv [*3] ##1 !clock_gate_n |=> !dev_dq_oe_n)
        else $error("fourth burst read word missing");
    a_deselect_release: assert property (
        desel ##1 !clock_gate_n |=> dev_dq_oe_n)
        else $error("bus not released after deselect");
    a_suspend_freeze: assert property (
        clock_gate_n |=> $stable(dev_dq) && $stable(dev_dq_oe_n))
        else $error("bus changed on a suspended edge");
    a_no_bus_clash: assert property (
        !(!dev_dq_oe_n && !ctl_dq_oe_n))
        else $error("both ends drive the bus");
    a_write_two_later: assert property (
        ld_wr ##1 !clock_gate_n |=> !ctl_dq_oe_n)
        else $error("write word not driven");
    a_burst_write_tail: assert property (
        ld_wr ##1 adv [*3] ##1 !clock_gate_n |=> !ctl_dq_oe_n)
        else $error("fourth burst write word missing");
    a_load_full_select: assert property (
        !advance_or_load && !chip_select_a_n |->
            chip_select_b && !chip_select_c_n)
        else $error("load with partial select");

    // Main scenarios reached
    c_burst_read: cover property (ld_rd ##1 adv [*3]);
    c_burst_write: cover property (ld_wr ##1 adv [*3]);
    c_suspend: cover property (clock_gate_n [*2]);
    c_deselect: cover property (desel);
endmodule

/* File: testbench/pipelined_zero_turnaround_sram_access_test.sv */
`timescale 1ns/1ps
module pipelined_zero_turnaround_sram_access_test import pzs_pkg::*;;
    // Request side of the controller
    logic                  sys_clk_i = 1'b0;
    logic                  reset_i;
    logic                  req_valid_i;
    logic                  req_ready_o;
    logic                  req_write_i;
    logic                  req_burst_i;
    logic [PZS_ADDR_W-1:0] req_addr_i;
    logic [PZS_LANES-1:0]  req_byte_en_i;
    logic                  hold_i;
    logic                  order_i;
    logic                  wdata_pull_o;
    logic [PZS_DATA_W-1:0] wdata_i;
    logic                  rdata_valid_o;
    logic [PZS_DATA_W-1:0] rdata_o;
    logic [2:0]            stat_s;    // Live, suspended, driving
    // Scoreboard: write words, expected array, expected reads
    logic [PZS_DATA_W-1:0] wbuf [0:255];
    logic [PZS_DATA_W-1:0] mem [logic [PZS_ADDR_W-1:0]];
    logic [PZS_DATA_W-1:0] eq [$];
    int                    wn;
    int                    wi = 0;
    int                    bad_count;
    int                    check_count;

    pzs_link_if pzs_link_if_inst ();
    pzs_sram_ctl pzs_sram_ctl_inst (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_write_i(req_write_i), .req_burst_i(req_burst_i),
        .req_addr_i(req_addr_i), .req_byte_en_i(req_byte_en_i),
        .hold_i(hold_i), .order_i(order_i),
        .wdata_pull_o(wdata_pull_o), .wdata_i(wdata_i),
        .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
        .link(pzs_link_if_inst));
    pzs_sram_dev pzs_sram_dev_inst (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .link(pzs_link_if_inst), .stat_burst_live_o(stat_s[2]),
        .stat_suspended_o(stat_s[1]), .stat_driving_o(stat_s[0]));
    pzs_link_checker pzs_link_checker_inst (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .read_write(pzs_link_if_inst.read_write),
        .advance_or_load(pzs_link_if_inst.advance_or_load),
        .chip_select_a_n(pzs_link_if_inst.chip_select_a_n),
        .chip_select_b(pzs_link_if_inst.chip_select_b),
        .chip_select_c_n(pzs_link_if_inst.chip_select_c_n),
        .clock_gate_n(pzs_link_if_inst.clock_gate_n),
        .ctl_dq_oe_n(pzs_link_if_inst.ctl_dq_oe_n),
        .dev_dq(pzs_link_if_inst.dev_dq),
        .dev_dq_oe_n(pzs_link_if_inst.dev_dq_oe_n));

    // 125 MHz clock
    always #4 sys_clk_i = ~sys_clk_i;

    // Head write word stays on wdata_i until pulled
    always @(posedge sys_clk_i) begin
        wi      <= wi + int'(wdata_pull_o);
        wdata_i <= wbuf[8'(wi + int'(wdata_pull_o))];
    end

    // Every returned word must equal the oldest expected one
    always @(posedge sys_clk_i) begin
        if (rdata_valid_o === 1'b1) begin
            if (eq.size() == 0) begin
                chk("read count", 36'h0, 36'h1);
            end else begin
                chk("read word", eq.pop_front(), rdata_o);
            end
        end
    end

    task automatic chk(input string what, input logic [35:0] exp,
                       input logic [35:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Offer one request until taken, then note its words
    task automatic access(input logic w, input logic b, input logic o,
                          input logic [18:0] a, input logic [3:0] be);
        int          n;
        logic [18:0] p;
        logic [35:0] d;
        req_valid_i   <= 1'b1;
        req_write_i   <= w;
        req_burst_i   <= b;
        req_addr_i    <= a;
        req_byte_en_i <= be;
        order_i       <= o;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (req_ready_o !== 1'b1 && n < 64);
        if (n >= 64) begin
            bad_count++;
            conclude();
        end
        for (int i = 0; i < (b ? PZS_BURST_N : 1); i++) begin
            // Low bits step in the chosen order and wrap
            p = {a[18:2], o ? (a[1:0] ^ 2'(i)) : (a[1:0] + 2'(i))};
            if (w) begin
                d = {p, 5'h0, 12'(wn)};
                wbuf[8'(wn)] = d;
                wn++;
                for (int l = 0; l < PZS_LANES; l++) begin
                    if (be[l]) mem[p][l*9 +: 9] = d[l*9 +: 9];
                end
            end else begin
                eq.push_back(mem[p]);
            end
        end
    endtask

    // Stop requesting; bounded wait until all words are through
    task automatic drain(input string name);
        int n;
        req_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while ((eq.size() != 0 || wi != wn) && n < 200);
        if (n >= 200) begin
            bad_count++;
            conclude();
        end
        $display("test %s done", name);
    endtask

    // Back-to-back writes, forwarded read, then reads
    task automatic t_singles();
        for (int i = 0; i < 4; i++) begin
            access(1, 0, 0, 19'(19'h100 + i), 4'hf);
        end
        access(0, 0, 0, 19'h103, 4'h0);
        for (int i = 0; i < 3; i++) begin
            access(0, 0, 0, 19'(19'h100 + i), 4'h0);
        end
        drain("singles");
    endtask

    // One lane written per word, then read back
    task automatic t_lanes();
        for (int l = 0; l < 4; l++) begin
            access(1, 0, 0, 19'(19'h100 + l), 4'h1 << l);
        end
        for (int l = 0; l < 4; l++) begin
            access(0, 0, 0, 19'(19'h100 + l), 4'h0);
        end
        drain("lanes");
    endtask

    // Back-to-back burst reads in both orders
    task automatic t_bursts();
        for (int o = 0; o < 2; o++) begin
            access(0, 1, o[0], 19'h101, 4'h0);
            access(0, 1, o[0], 19'h102, 4'h0);
        end
        drain("bursts");
    endtask

    // Burst writes, then burst reads over the same words
    task automatic t_burst_wr();
        access(1, 1, 1, 19'h202, 4'hf);
        access(1, 1, 0, 19'h203, 4'h6);
        access(0, 1, 0, 19'h200, 4'h0);
        access(0, 1, 1, 19'h203, 4'h0);
        drain("burst_write");
    endtask

    // Suspend in mid burst and between write and read
    task automatic t_suspend();
        access(0, 1, 1, 19'h201, 4'h0);
        req_valid_i <= 1'b0;
        @(posedge sys_clk_i);
        hold_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        chk("status", 36'h7, {33'h0, stat_s});
        hold_i <= 1'b0;
        access(1, 0, 0, 19'h300, 4'hf);
        req_valid_i <= 1'b0;
        @(posedge sys_clk_i);
        hold_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        hold_i <= 1'b0;
        access(0, 0, 0, 19'h300, 4'h0);
        drain("suspend");
    endtask

    initial begin
        reset_i       = 1'b1;
        req_valid_i   = 1'b0;
        req_write_i   = 1'b0;
        req_burst_i   = 1'b0;
        req_addr_i    = 19'h0;
        req_byte_en_i = 4'h0;
        hold_i        = 1'b0;
        order_i       = 1'b0;
        wn            = 0;
        bad_count     = 0;
        check_count   = 0;
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        t_singles();
        t_lanes();
        t_bursts();
        t_burst_wr();
        t_suspend();
        conclude();
    end
endmodule
